// ### inc/pwtrap_pkg.sv
// Summary of operation
// - Walks allowed only while walker enable set.
// - Size field makes mask ANDed with hash.
// - Size below 32K bytes raises reserved fault.
// - Size capped at 2^61 long, 2^52 short.
// - Format bit selects 8 or 32 byte entries.
// - Walk address is base ORed with index.
// - All base field bits are implemented.
// - Unimplemented base makes every walk miss while walker enable set.
// - Interruption registers record each event taken while collect set.
// - Access only while collect bit clear, else fault.
// - Contents may be overwritten while collecting.
// - Contents undefined after software clears collect.
// - Undefined after software set until next interruption.
// - Event taken while collect set copies status word into saved.
// - Return restores status, pointer and frame.
// - Cause written always, except nested data miss.
// - Several cause flags may be set together.
// - Detail code and legacy vector hold extras.
// - Cause bits 32 fetch, 33 write, 34 read.
`default_nettype none
package pwtrap_pkg;
  // ----------------------------------------------------------------
  // Register offsets on the bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ANCH_LO = 8'h00; // Anchor bits 31:0.
  localparam logic [7:0] OFS_ANCH_HI = 8'h04; // Anchor bits 63:32.
  localparam logic [7:0] OFS_CTRL    = 8'h08; // Collect and valid.
  localparam logic [7:0] OFS_FAULT   = 8'h0C; // Sticky fault flags.
  localparam logic [7:0] OFS_SAVE_LO = 8'h10; // First saved word.
  localparam logic [7:0] OFS_LAST_HI = 8'h2C; // Last saved word.
  // ----------------------------------------------------------------
  // Anchor fields and limits.
  // ----------------------------------------------------------------
  localparam int unsigned VE_POS   = 0;  // Walker enable.
  localparam int unsigned SIZE_LO  = 2;  // Size field low bit.
  localparam int unsigned FMT_POS  = 8;  // Entry format select.
  localparam int unsigned BASE_LO  = 15; // Base field low bit.
  localparam logic [63:0] ANCH_WMASK = 64'hFFFFFFFFFFFF81FD;
  localparam logic [63:0] ANCH_RST   = 64'h0000000000000000;
  localparam logic [5:0]  SIZE_MIN   = 6'h0F; // 32K bytes.
  localparam logic [5:0]  SIZE_LONG  = 6'h3D; // 2^61 bytes.
  localparam logic [5:0]  SIZE_SHORT = 6'h34; // 2^52 bytes.
  // ----------------------------------------------------------------
  // Cause register flag positions.
  // ----------------------------------------------------------------
  localparam int unsigned CS_X  = 32; // Instruction fetch.
  localparam int unsigned CS_W  = 33; // Write.
  localparam int unsigned CS_R  = 34; // Read.
  localparam int unsigned CS_SP = 36; // Speculative load.
  localparam int unsigned CS_NI = 39; // Nested interruption.
  localparam logic CTRL_RST = 1'b0; // Collect bit after reset.
endpackage : pwtrap_pkg
`default_nettype wire

// ### hw/pwtrap_mask.sv
`timescale 1ns/10ps
`default_nettype none
// Builds the table mask from the size field, capped per format.
module pwtrap_mask
  import pwtrap_pkg::*;
(
  // Anchor fields.
  input  wire logic [5:0]  size,
  input  wire logic        long_fmt,
  // Resulting mask.
  output logic      [63:0] mask
);
  // ----------------------------------------------------------------
  // Size limit.
  // ----------------------------------------------------------------
  wire logic [5:0] cap  = long_fmt ? SIZE_LONG : SIZE_SHORT;
  wire logic [5:0] eff  = (size > cap) ? cap : size;
  // One mask bit per address bit: set below the table size.
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_bit
      assign mask[gi] = (7'(gi) < {1'b0, eff});
    end
  endgenerate
endmodule // pwtrap_mask
`default_nettype wire

// ### hw/pwtrap_vachk.sv
`timescale 1ns/10ps
`default_nettype none
// Flags a virtual address whose upper bits are not a sign extension.
module pwtrap_vachk #(
  parameter int unsigned VA_BITS = 50 // Implemented address bits.
) (
  // Address under test.
  input  wire logic [63:0] addr,
  // High when the address is implemented.
  output logic             impl
);
  initial begin
    if (VA_BITS < 16 || VA_BITS > 64) begin
      $error("VA_BITS out of range");
    end
  end
  // ----------------------------------------------------------------
  // Top bits must all equal the highest implemented bit.
  // ----------------------------------------------------------------
  wire logic [63:0] ext = {64{addr[VA_BITS-1]}};
  wire logic [63:0] hi  = ~(64'hFFFFFFFFFFFFFFFF >> (64 - VA_BITS));
  assign impl = ((addr ^ ext) & hi) == 64'h0;
endmodule // pwtrap_vachk
`default_nettype wire

// ### hw/pwtrap_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Table anchor and interruption state registers behind APB.
module pwtrap_regs
  import pwtrap_pkg::*;
#(
  parameter int unsigned VA_BITS = 50, // Implemented VA bits.
  parameter int unsigned IC_BIT  = 13  // Collect bit in status word.
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Interruption event from the core.
  input  wire logic        intr_take,
  input  wire logic [63:0] intr_psr,
  input  wire logic [63:0] intr_ip,
  input  wire logic [63:0] intr_frame,
  input  wire logic        ev_exec,
  input  wire logic        ev_write,
  input  wire logic        ev_read,
  input  wire logic        ev_spec,
  input  wire logic        ev_sema,
  input  wire logic        ev_spec_load,
  input  wire logic        ev_nested_dtlb,
  input  wire logic [15:0] ev_code,
  input  wire logic [7:0]  ev_vector,
  // Return from interruption.
  input  wire logic        rfi_req,
  output logic             rfi_done,
  output logic      [63:0] rfi_psr,
  output logic      [63:0] rfi_ip,
  output logic      [63:0] rfi_frame,
  output logic             interruption_collect_bit,
  // Table walker.
  input  wire logic        walk_req,
  input  wire logic [63:0] walk_hash,
  output logic             walk_go,
  output logic             walk_miss,
  output logic      [63:0] walk_addr,
  output logic             walk_long,
  // Fault pulses.
  output logic             rsv_fault,
  output logic             illegal_fault
);
  initial begin
    if (IC_BIT > 63) begin
      $error("IC_BIT out of range");
    end
  end

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [63:0] anch_q;       // Page table anchor register.
  logic [63:0] saved_q;      // Saved status register.
  logic [63:0] cause_q;      // Interruption cause register.
  logic [63:0] iip_q;        // Interrupted pointer register.
  logic [63:0] ifs_q;        // Interrupted frame register.
  logic        collect_q;    // Collection bit.
  logic        valid_q;      // Saved contents are defined.
  logic [1:0]  flt_q;        // Sticky faults: reserved, illegal.
  logic [31:0] rdata_q;      // Read data captured at setup.
  logic        rfi_done_q;   // Return pulse.
  logic [63:0] rpsr_q;       // Restored status word.
  logic [63:0] rip_q;        // Restored pointer.
  logic [63:0] rfs_q;        // Restored frame.
  logic        go_q;         // Walk launched.
  logic        miss_q;       // Walk ends in a miss.
  logic [63:0] waddr_q;      // Walk reference address.
  logic        rsv_q;        // Reserved fault pulse.
  logic        ill_q;        // Illegal operation pulse.

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  wire logic acc   = psel & penable;
  wire logic wr    = acc & pwrite;
  wire logic is_al = (paddr == OFS_ANCH_LO);
  wire logic is_ah = (paddr == OFS_ANCH_HI);
  wire logic is_ct = (paddr == OFS_CTRL);
  wire logic is_ft = (paddr == OFS_FAULT);
  // Saved words sit at 0x10..0x2C, one aligned word each.
  wire logic is_sv = (paddr >= OFS_SAVE_LO) && (paddr <= OFS_LAST_HI)
                     && (paddr[1:0] == 2'b00);
  wire logic known = is_al | is_ah | is_ct | is_ft | is_sv;
  // Saved words are locked while collection is on.
  wire logic blk   = is_sv & collect_q;
  // Size check on a low-word anchor write.
  wire logic [5:0] wsize = pwdata[SIZE_LO +: 6];
  wire logic bad_sz = is_al & (wsize < SIZE_MIN);
  wire logic err   = ~known | blk | (pwrite & bad_sz);
  wire logic ok_wr = wr & ~err;
  // Word select inside the saved block.
  wire logic [2:0] sidx = 3'((paddr - OFS_SAVE_LO) >> 3);
  wire logic       shi  = paddr[2];

  // Zero wait states; errors are flagged in the access phase.
  assign pready  = 1'b1;
  assign pslverr = acc & err;
  assign prdata  = rdata_q;

  // ----------------------------------------------------------------
  // Read mux.
  // ----------------------------------------------------------------
  wire logic [63:0] sv_w = (sidx == 3'h0) ? saved_q :
                           (sidx == 3'h1) ? cause_q :
                           (sidx == 3'h2) ? iip_q   : ifs_q;
  wire logic [31:0] rd_w = ~known ? 32'h0 :
                           blk    ? 32'h0 :
                           is_al  ? anch_q[31:0] :
                           is_ah  ? anch_q[63:32] :
                           is_ct  ? {30'h0, valid_q, collect_q} :
                           is_ft  ? {30'h0, flt_q} :
                           shi    ? sv_w[63:32] : sv_w[31:0];

  // Read data is latched in the setup phase so prdata is a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else if (psel & ~penable) begin
      rdata_q <= rd_w;
    end
  end

  // ----------------------------------------------------------------
  // Anchor register.
  // ----------------------------------------------------------------
  // Reserved bits are masked on write so they always read zero.
  wire logic [63:0] anch_wv = {is_ah ? pwdata : anch_q[63:32],
                               is_al ? pwdata : anch_q[31:0]};
  wire logic [63:0] anch_d  = (ok_wr & (is_al | is_ah)) ?
                              (anch_wv & ANCH_WMASK) : anch_q;
  // The whole base field is stored, whatever VA_BITS is.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anch_q <= ANCH_RST;
    end else begin
      anch_q <= anch_d;
    end
  end

  // ----------------------------------------------------------------
  // Collection bit and content validity.
  // ----------------------------------------------------------------
  wire logic take_col = intr_take & collect_q;
  wire logic sw_ct    = ok_wr & is_ct;
  // A taken event wins over a return and over software.
  wire logic col_d = intr_take ? 1'b0 :
                     rfi_req   ? saved_q[IC_BIT] :
                     sw_ct     ? pwdata[0] : collect_q;
  // Only an interruption makes the contents defined; any software
  // write of the collect bit makes them undefined again.
  wire logic val_d = take_col ? 1'b1 :
                     sw_ct    ? 1'b0 : valid_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collect_q <= CTRL_RST;
      valid_q   <= 1'b0;
    end else begin
      collect_q <= col_d;
      valid_q   <= val_d;
    end
  end

  // ----------------------------------------------------------------
  // Cause word assembly.
  // ----------------------------------------------------------------
  logic [63:0] cause_ev; // Cause value for this event.
  always_comb begin
    cause_ev        = 64'h0;
    cause_ev[15:0]  = ev_code;
    cause_ev[23:16] = ev_vector;
    cause_ev[CS_X]  = ev_exec;
    // A semaphore reads and writes; a speculative load reads.
    cause_ev[CS_W]  = ev_write | ev_sema;
    cause_ev[CS_R]  = ev_read | ev_sema | ev_spec_load;
    cause_ev[CS_SP] = ev_spec | ev_spec_load;
    cause_ev[CS_NI] = ~collect_q;
  end

  // ----------------------------------------------------------------
  // Saved interruption registers.
  // ----------------------------------------------------------------
  // Hardware capture wins over a software write in the same cycle.
  wire logic sw_sv = ok_wr & is_sv;
  function automatic logic [63:0] upd(input logic [63:0] cur,
                                      input logic        hi,
                                      input logic [31:0] d);
    upd = hi ? {d, cur[31:0]} : {cur[63:32], d};
  endfunction
  wire logic [63:0] saved_d = take_col ? intr_psr :
    (sw_sv & sidx == 3'h0) ? upd(saved_q, shi, pwdata) : saved_q;
  wire logic [63:0] cause_d = (intr_take & ~ev_nested_dtlb) ?
    cause_ev :
    (sw_sv & sidx == 3'h1) ? upd(cause_q, shi, pwdata) : cause_q;
  wire logic [63:0] iip_d = take_col ? intr_ip :
    (sw_sv & sidx == 3'h2) ? upd(iip_q, shi, pwdata) : iip_q;
  wire logic [63:0] ifs_d = take_col ? intr_frame :
    (sw_sv & sidx == 3'h3) ? upd(ifs_q, shi, pwdata) : ifs_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_q <= 64'h0;
      cause_q <= 64'h0;
      iip_q   <= 64'h0;
      ifs_q   <= 64'h0;
    end else begin
      saved_q <= saved_d;
      cause_q <= cause_d;
      iip_q   <= iip_d;
      ifs_q   <= ifs_d;
    end
  end

  // ----------------------------------------------------------------
  // Return from interruption.
  // ----------------------------------------------------------------
  // Restored values are held until the next return.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfi_done_q <= 1'b0;
      rpsr_q     <= 64'h0;
      rip_q      <= 64'h0;
      rfs_q      <= 64'h0;
    end else begin
      rfi_done_q <= rfi_req;
      if (rfi_req) begin
        rpsr_q <= saved_q;
        rip_q  <= iip_q;
        rfs_q  <= ifs_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Faults. A new fault wins over a clear in the same cycle.
  // ----------------------------------------------------------------
  wire logic set_rsv = wr & bad_sz & ~blk;
  wire logic set_ill = acc & blk;
  wire logic [1:0] w1c = (ok_wr & is_ft) ? pwdata[1:0] : 2'b00;
  wire logic [1:0] flt_d = (flt_q & ~w1c) | {set_ill, set_rsv};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= 2'b00;
      rsv_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      flt_q <= flt_d;
      rsv_q <= set_rsv;
      ill_q <= set_ill;
    end
  end

  // ----------------------------------------------------------------
  // Table walker address.
  // ----------------------------------------------------------------
  logic [63:0] mask;  // Index mask from the size field.
  logic        impl;  // Base is an implemented address.
  wire logic [63:0] base = {anch_q[63:BASE_LO], 15'h0};
  pwtrap_mask u_mask (
    .size     (anch_q[SIZE_LO +: 6]),
    .long_fmt (anch_q[FMT_POS]),
    .mask     (mask)
  );
  pwtrap_vachk #(.VA_BITS(VA_BITS)) u_vachk (
    .addr (base),
    .impl (impl)
  );
  // Misalignment of base is not checked; software owns that.
  wire logic [63:0] waddr_d = base | (walk_hash & mask);
  wire logic en = anch_q[VE_POS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q    <= 1'b0;
      miss_q  <= 1'b0;
      waddr_q <= 64'h0;
    end else begin
      go_q    <= walk_req & en & impl;
      miss_q  <= walk_req & en & ~impl;
      if (walk_req) begin
        waddr_q <= waddr_d;
      end
    end
  end

  assign walk_go   = go_q;
  assign walk_miss = miss_q;
  assign walk_addr = waddr_q;
  assign walk_long = anch_q[FMT_POS];
  assign rfi_done  = rfi_done_q;
  assign rfi_psr   = rpsr_q;
  assign rfi_ip    = rip_q;
  assign rfi_frame = rfs_q;
  assign interruption_collect_bit = collect_q;
  assign rsv_fault     = rsv_q;
  assign illegal_fault = ill_q;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take_col;
    intr_take && collect_q;
  endsequence
  sequence s_sema;
    intr_take && ev_sema && !ev_nested_dtlb;
  endsequence
  property p_gate;
    walk_req && !en |=> !walk_go && !walk_miss;
  endproperty
  a_gate: assert property (p_gate) else $error("walk while off");
  property p_addr;
    walk_req && en |=>
      walk_addr == ($past(base) | ($past(walk_hash) & $past(mask)));
  endproperty
  a_addr: assert property (p_addr) else $error("bad walk addr");
  property p_size;
    wr && is_al && bad_sz |=> rsv_fault && $stable(anch_q);
  endproperty
  a_size: assert property (p_size) else $error("no size fault");
  property p_cap;
    mask[63:61] == 3'h0 && (walk_long || mask[63:52] == 12'h0);
  endproperty
  a_cap: assert property (p_cap) else $error("mask too wide");
  property p_miss;
    walk_req && en && !impl |=> walk_miss && !walk_go;
  endproperty
  a_miss: assert property (p_miss) else $error("no miss");
  property p_ill;
    set_ill && !intr_take |-> pslverr ##1 illegal_fault && $stable(saved_q);
  endproperty
  a_ill: assert property (p_ill) else $error("no illegal");
  property p_save;
    s_take_col |=> saved_q == $past(intr_psr) && !collect_q && valid_q;
  endproperty
  a_save: assert property (p_save) else $error("psr not saved");
  property p_nest;
    intr_take && ev_nested_dtlb && !sw_sv |=> $stable(cause_q);
  endproperty
  a_nest: assert property (p_nest) else $error("cause written");
  property p_sema;
    s_sema |=> cause_q[CS_W] && cause_q[CS_R];
  endproperty
  a_sema: assert property (p_sema) else $error("sema flags");
  property p_rfi;
    rfi_req |=> rfi_done && rfi_psr == $past(saved_q)
                && rfi_ip == $past(iip_q);
  endproperty
  a_rfi: assert property (p_rfi) else $error("rfi restore");
endmodule // pwtrap_regs
`default_nettype wire

// ### sim/tb_pwtrap_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench: drivers queue expectations, a monitor compares them.
module tb_pwtrap_regs
  import pwtrap_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, outputs and bookkeeping.
  // ----------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic rd, err, rsv, ill;}
    pwtrap_apb_t;
  typedef struct packed {logic go, miss; logic [63:0] a; logic lng;}
    pwtrap_wk_t;
  typedef struct packed {logic [63:0] p, ip, fr; logic col;} pwtrap_rfi_t;
  localparam int unsigned ICB = 13; // Collect bit inside the status word.
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, intr_take = 1'b0, rfi_req = 1'b0;
  logic        walk_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, lo, hi;
  logic [63:0] intr_psr = 64'h0, intr_ip = 64'h0, intr_frame = 64'h0;
  logic [63:0] walk_hash = 64'h0, h, tp, tip, tfr, c1;
  logic [6:0]  evs = 7'h00, te;  // {nested,specld,sema,spec,rd,wr,exec}.
  logic [15:0] ev_code = 16'h0, tc;
  logic [7:0]  ev_vector = 8'h0, tv;
  logic [5:0]  sz, cap;
  logic        pready, pslverr, rfi_done, walk_go, walk_miss, walk_long;
  logic        interruption_collect_bit, rsv_fault, illegal_fault, fmt;
  logic [31:0] prdata;
  logic [63:0] rfi_psr, rfi_ip, rfi_frame, walk_addr;
  pwtrap_apb_t aq[$];   // Pending bus results.
  pwtrap_wk_t  wq[$];   // Pending walker results.
  pwtrap_rfi_t rq[$];   // Pending return results.
  pwtrap_apb_t ae, fe;
  pwtrap_wk_t  we;
  pwtrap_rfi_t re;
  logic        fpend = 1'b0, wseen = 1'b0;
  integer      seed = 94323;
  int          n_fail = 0, checked = 0, cyc = 0, i;

  pwtrap_regs #(.VA_BITS(50), .IC_BIT(ICB)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .intr_take(intr_take),
    .intr_psr(intr_psr), .intr_ip(intr_ip), .intr_frame(intr_frame),
    .ev_exec(evs[0]), .ev_write(evs[1]), .ev_read(evs[2]),
    .ev_spec(evs[3]), .ev_sema(evs[4]), .ev_spec_load(evs[5]),
    .ev_nested_dtlb(evs[6]), .ev_code(ev_code), .ev_vector(ev_vector),
    .rfi_req(rfi_req), .rfi_done(rfi_done), .rfi_psr(rfi_psr),
    .rfi_ip(rfi_ip), .rfi_frame(rfi_frame),
    .interruption_collect_bit(interruption_collect_bit),
    .walk_req(walk_req), .walk_hash(walk_hash), .walk_go(walk_go),
    .walk_miss(walk_miss), .walk_addr(walk_addr), .walk_long(walk_long),
    .rsv_fault(rsv_fault), .illegal_fault(illegal_fault));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Checking and closing.
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hung handshake ends the run here; the run needs under two hundred cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end

  // Outputs are settled at the falling edge, so the monitor samples there.
  always @(negedge pclk) begin
    if (fpend) begin
      chk("rsv_fault", rsv_fault, fe.rsv);
      chk("illegal_fault", illegal_fault, fe.ill);
    end
    fpend = 1'b0;
    if (psel && penable && aq.size() > 0) begin
      ae = aq.pop_front();
      chk("pslverr", pslverr, ae.err);
      if (ae.rd) chk("prdata", prdata, ae.d);
      fe = ae;
      fpend = 1'b1;
    end
    if (wseen && wq.size() > 0) begin
      we = wq.pop_front();
      chk("walk_go", walk_go, we.go);
      chk("walk_miss", walk_miss, we.miss);
      chk("walk_long", walk_long, we.lng);
      if (we.go) chk("walk_addr", walk_addr, we.a);
    end
    wseen = walk_req;
    if (rfi_done === 1'b1 && rq.size() > 0) begin
      re = rq.pop_front();
      chk("rfi_psr", rfi_psr, re.p);
      chk("rfi_ip", rfi_ip, re.ip);
      chk("rfi_frame", rfi_frame, re.fr);
      chk("collect", interruption_collect_bit, re.col);
    end
  end

  // ----------------------------------------------------------------
  // Drivers: bus and walk drivers note what they expect before they act.
  // ----------------------------------------------------------------
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic ee, logic er, logic ei);
    aq.push_back('{d, !w, ee, er, ei});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic ee = 1'b0,
                    logic er = 1'b0, logic ei = 1'b0);
    apb(1'b1, a, d, ee, er, ei);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic ee = 1'b0,
                    logic ei = 1'b0);
    apb(1'b0, a, e, ee, 1'b0, ei);
  endtask

  task automatic rd64(logic [7:0] a, logic [63:0] e);
    rd(a, e[31:0]);
    rd(a + 8'h04, e[63:32]);
  endtask

  task automatic walk(logic go, logic miss, logic [63:0] a, logic lng);
    wq.push_back('{go, miss, a, lng});
    @(posedge pclk);
    walk_req <= 1'b1;
    walk_hash <= h;
    @(posedge pclk);
    walk_req <= 1'b0;
  endtask

  // Draws a fresh interruption event without the nested data miss.
  task automatic rnd();
    tp = {$random(seed), $random(seed)};
    tip = {$random(seed), $random(seed)};
    tfr = {$random(seed), $random(seed)};
    te = 7'($random(seed)) & 7'h3F;
    tc = 16'($random(seed));
    tv = 8'($random(seed));
  endtask

  task automatic take();
    @(posedge pclk);
    intr_take <= 1'b1;
    {intr_psr, intr_ip, intr_frame, evs, ev_code, ev_vector} <=
      {tp, tip, tfr, te, tc, tv};
    @(posedge pclk);
    intr_take <= 1'b0;
  endtask

  // Cause word as the flags of one event should leave it.
  function automatic logic [63:0] cz(logic ni);
    cz = {24'h0, ni, 2'b00, te[3] | te[5], 1'b0, te[2] | te[4] | te[5],
          te[1] | te[4], te[0], 8'h00, tv, tc};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_ANCH_LO, 32'h0);
    rd(OFS_CTRL, 32'h0);
    rd(8'h30, 32'h0, 1'b1);
    wr(OFS_ANCH_LO, 32'h0000_7E3B, 1'b1, 1'b1);
    rd(OFS_ANCH_LO, 32'h0);
    rd(OFS_FAULT, 32'h1);
    wr(OFS_FAULT, 32'h3);
    // Smallest legal size, then the largest size clamped per format.
    for (i = 0; i < 3; i++) begin
      fmt = (i == 2);
      sz = (i == 0) ? SIZE_MIN : 6'h3F;
      cap = fmt ? SIZE_LONG : SIZE_SHORT;
      lo = $random(seed);
      lo[14:0] = {6'h3F, fmt, sz, 2'b11};
      hi = $random(seed) & 32'h0001_FFFF;
      // Large tables need a size-aligned base; zero is the only one
      // that is also an implemented address.
      if (i > 0) begin
        lo[31:15] = 17'h0;
        hi = 32'h0;
      end
      h = {$random(seed), $random(seed)};
      wr(OFS_ANCH_LO, lo);
      wr(OFS_ANCH_HI, hi);
      rd(OFS_ANCH_LO, lo & ANCH_WMASK[31:0]);
      rd(OFS_ANCH_HI, hi);
      walk(1'b1, 1'b0, {hi, lo[31:15], 15'h0} |
           (h & ((64'h1 << (sz < cap ? sz : cap)) - 64'h1)), fmt);
    end
    wr(OFS_ANCH_HI, 32'h4000_0000);
    walk(1'b0, 1'b1, 64'h0, 1'b1);
    wr(OFS_ANCH_LO, 32'h0000_003C);
    walk(1'b0, 1'b0, 64'h0, 1'b0);
    // Capture with collection on; the saved word re-enables collection.
    wr(OFS_CTRL, 32'h1);
    rnd();
    tp[ICB] = 1'b1;
    te[4] = 1'b1;
    take();
    c1 = cz(1'b0);
    rq.push_back('{tp, tip, tfr, 1'b1});
    rd(OFS_CTRL, 32'h2);
    rd64(OFS_SAVE_LO, tp);
    rd64(8'h18, c1);
    rd64(8'h20, tip);
    rd64(8'h28, tfr);
    h = tp;
    rnd();
    take();
    c1 = cz(1'b1);
    rd64(OFS_SAVE_LO, h);
    rd64(8'h18, c1);
    te[6] = 1'b1;
    tc = ~tc;
    take();
    rd64(8'h18, c1);
    // Software may rewrite a saved word while collection is off.
    wr(8'h1C, {tv, tv, tc});
    rd(8'h1C, {tv, tv, tc});
    @(posedge pclk);
    rfi_req <= 1'b1;
    @(posedge pclk);
    rfi_req <= 1'b0;
    rd(OFS_SAVE_LO, 32'h0, 1'b1, 1'b1);
    wr(8'h1C, 32'h1, 1'b1, 1'b0, 1'b1);
    rd(OFS_FAULT, 32'h2);
    // A software write of the collect bit leaves the contents undefined.
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("pending", 64'(aq.size() + wq.size() + rq.size()), 64'h0);
    summarize();
  end
endmodule // tb_pwtrap_regs
`default_nettype wire
